/* dv/flash_array_model.sv */
// flash array stand-in that tallies sector erases
`timescale 1ns/1ps
`default_nettype none
module flash_array_model (
    input wire logic clk_i,
    input wire logic erase_req_i,
    input wire logic [15:0] erase_base_i,
    output var int n_erase_o,
    output var logic [8:0] last_sector_o
);
    int tally = 0;
    assign n_erase_o = tally;
    // sector index from the top nine bits
    always @(posedge clk_i) begin
        if (erase_req_i) begin
            tally <= tally + 1;
            last_sector_o <= erase_base_i[15:7];
        end
    end
endmodule
`default_nettype wire

/* dv/flash_seq_monitor.sv */
// port-level checks for the sector-erase sequencer
`timescale 1ns/1ps
`default_nettype none
module flash_seq_monitor
    import flash_seq_pkg::*;
#(parameter int ERASE_CYCLES_P = ERASE_CYCLES) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic erase_req_o,
    input wire logic [15:0] erase_base_o,
    input wire logic [15:0] reset_vector_o,
    input wire logic busy_o
);
    import flash_seq_pkg::*;
    typedef struct packed {logic [19:0] busy_cnt; logic [3:0] up_cnt;} mon_s;
    mon_s mon_reg, mon_next;
    // up_cnt saturates so the vector check stays armed until the next reset
    always_comb begin
        mon_next.busy_cnt = busy_o ? mon_reg.busy_cnt + 20'h00001 : 20'h00000;
        mon_next.up_cnt = mon_reg.up_cnt + {3'h0, mon_reg.up_cnt != 4'hF};
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mon_reg <= '0;
        end else begin
            mon_reg <= mon_next;
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside answer");
    vector_hold_a: assert property (mon_reg.up_cnt >= 4'h6 |-> $stable(reset_vector_o))
        else $error("reset vector moved");
    req_pulse_a: assert property (erase_req_o |=> !erase_req_o)
        else $error("erase request too long");
    req_cause_a: assert property (erase_req_o |-> $past(wr_i)
        && $past(addr_i) == OFS_FLASH_CONTROL && ($past(wdata_i) & 8'hF1) == 8'hA1)
        else $error("erase without trigger");
    req_idle_a: assert property (erase_req_o |-> busy_o && !$past(busy_o))
        else $error("erase while busy");
    base_align_a: assert property (erase_req_o |-> erase_base_o[6:0] == 7'h00)
        else $error("sector base unaligned");
    busy_start_a: assert property ($rose(busy_o) |-> erase_req_o)
        else $error("busy without erase");
    busy_max_a: assert property (busy_o |-> mon_reg.busy_cnt < ERASE_CYCLES_P)
        else $error("erase too long");
endmodule
bind flash_boot_protect_sector_erase flash_seq_monitor #(.ERASE_CYCLES_P(ERASE_CYCLES_P)) mon (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .erase_req_o(erase_req_o), .busy_o(busy_o),
    .erase_base_o(erase_base_o), .reset_vector_o(reset_vector_o)
);
`default_nettype wire

/* dv/tb_flash_boot_protect_sector_erase.sv */
// random and corner-case bench for the sector-erase sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_flash_boot_protect_sector_erase;
    import flash_seq_pkg::*;
    // short erase keeps the run small
    localparam int N = 50;
    logic clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, irq_pending_i = 1'b0;
    logic tool_mode_i = 1'b0, emulator_tool_mode_i = 1'b0, last_st = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00, option_byte_i = 8'hFF, rdata_o, d;
    logic [15:0] erase_base_o, reset_vector_o;
    logic erase_req_o, pm_write_grant_o, busy_o;
    logic [8:0] sector;
    logic [31:0] seed = 32'h0000E45D;
    int errors = 0, n_compared = 0, n_exp = 0, n_erase;
    always #12.5 clk_i = ~clk_i;
    flash_boot_protect_sector_erase #(.ERASE_CYCLES_P(N)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .tool_mode_i(tool_mode_i), .emulator_tool_mode_i(emulator_tool_mode_i),
        .irq_pending_i(irq_pending_i), .option_byte_i(option_byte_i), .rdata_o(rdata_o),
        .erase_req_o(erase_req_o), .erase_base_o(erase_base_o), .busy_o(busy_o),
        .pm_write_grant_o(pm_write_grant_o), .reset_vector_o(reset_vector_o));
    flash_array_model partner (.clk_i(clk_i), .erase_req_i(erase_req_o),
        .erase_base_i(erase_base_o), .n_erase_o(n_erase), .last_sector_o(sector));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    task automatic restart(input logic [7:0] o, input int k);
        logic [15:0] v;
        v = (o & 8'h98) != 8'h00 ? VECTOR_DEFAULT : REGION_BASE + (16'h0100 << o[6:5]);
        rst_i <= 1'b1;
        option_byte_i <= o;
        last_st = 1'b0;
        repeat (k) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        #1 chk(reset_vector_o, v);
        rd(OFS_OPTION_BYTE);
        chk(16'(d), 16'(o));
    endtask
    // kind 0 erased, 1 refused with fail status, 2 ignored
    task automatic erase(input logic [15:0] sa, input logic [7:0] key, input logic [7:0] cmd,
        input int kind, input int ab);
        int n;
        n = 0;
        wr(OFS_PROGRAM_ENABLE_KEY, key);
        wr(OFS_SECTOR_ADDR_HIGH, sa[15:8]);
        wr(OFS_SECTOR_ADDR_LOW, sa[7:0]);
        wr(OFS_FLASH_CONTROL, cmd);
        #1 chk(16'(erase_req_o), 16'(kind == 0));
        if (kind == 0) chk(erase_base_o, sa & 16'hFF80);
        n_exp += int'(kind == 0);
        // wait it out, status read at cycle 3 must show the old value, irq only when asked
        while (busy_o && n < 2 * N) begin
            @(posedge clk_i);
            n++;
            irq_pending_i <= ab != 0 && n >= ab;
            rd_i <= n == 3;
            addr_i <= OFS_FLASH_CONTROL;
            #1;
            if (n == 4) chk(16'(rdata_o[3]), 16'(last_st));
        end
        irq_pending_i <= 1'b0;
        if (ab != 0) chk(16'(n < N), 16'h0001);
        else chk(16'(n), kind == 0 ? 16'(N) : 16'h0000);
        if (kind != 2) last_st = kind == 1 || ab != 0;
        wr(OFS_PROGRAM_ENABLE_KEY, KEY_RESET);
        rd(OFS_FLASH_CONTROL);
        chk(16'(d[CTRL_STATUS_BIT]), 16'(last_st));
        chk(16'(n_erase), 16'(n_exp));
        if (kind == 0) chk(16'(sector), 16'(sa[15:7]));
    endtask
    task automatic pmw(input logic [15:0] a, input logic exp, input logic inr);
        wr(OFS_PROGRAM_ENABLE_KEY, KEY_VALUE);
        wr(OFS_FLASH_CONTROL, 8'h51);
        wr(OFS_PM_WRITE_HIGH, a[15:8]);
        wr(OFS_PM_WRITE_LOW, a[7:0]);
        @(posedge clk_i);
        #1 chk(16'(pm_write_grant_o), 16'(exp));
        rd(OFS_PM_STATUS);
        chk(16'(d), 16'({inr, !exp, exp}));
        wr(OFS_PROGRAM_ENABLE_KEY, KEY_RESET);
    endtask
    task automatic wrap_up();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // run needs about 1200 cycles, limit is 16000
    initial begin
        #400000;
        errors++;
        wrap_up();
    end
    initial begin
        logic [7:0] o;
        logic [15:0] last, s;
        logic [31:0] r;
        logic prot;
        restart(8'hFF, 12);
        for (int i = 0; i < 6; i++) begin
            r = rnd();
            o = {r[7:4], i == 5, i == 4, i[1:0]};
            restart(o, 3);
            prot = (o & 8'h0C) == 8'h00;
            last = REGION_BASE + (16'h0100 << o[1:0]) - 16'h0001;
            erase({8'h01, 1'b0, r[14:8]}, KEY_VALUE, 8'hA1, prot, 0);
            erase(last - 16'h007F, KEY_VALUE, 8'hA1, prot, 0);
            erase(last + 16'h0001, KEY_VALUE, 8'hA1, 0, 0);
            pmw(last, !prot, prot);
            pmw(last + 16'h0001, 1'b1, 1'b0);
        end
        restart(8'h00, 3);
        r = rnd();
        s = {r[15:8] | 8'h10, r[23:16]};
        erase(s, KEY_VALUE, 8'hA1, 0, 10);
        erase(s, KEY_VALUE, 8'hA1, 0, 0);
        erase(s, r[31:24] == KEY_VALUE ? 8'h00 : r[31:24], 8'hA1, 2, 0);
        erase(s, KEY_VALUE, 8'hA0, 2, 0);
        tool_mode_i <= 1'b1;
        erase(s, KEY_VALUE, 8'hA1, 2, 0);
        pmw(16'h0100, 1'b1, 1'b1);
        tool_mode_i <= 1'b0;
        emulator_tool_mode_i <= 1'b1;
        erase(s, KEY_VALUE, 8'hA1, 2, 0);
        emulator_tool_mode_i <= 1'b0;
        erase(s, KEY_VALUE, 8'hA1, 0, 0);
        rd(4'hF);
        chk(16'(d), 16'h0000);
        wrap_up();
    end
endmodule
`default_nettype wire

/* hw/erase_timer.sv */
// erase duration counter with abort
`timescale 1ns/1ps
`default_nettype none
module erase_timer
    import flash_seq_pkg::*;
#(
    parameter int ERASE_CYCLES_P = ERASE_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic abort_i,
    output logic busy_o,
    output logic done_o,
    output logic fail_o
);
    typedef struct packed {
        erase_state_e st;
        logic [CNT_W-1:0] cnt;
        logic done;
        logic fail;
    } timer_s;
    timer_s s_reg, s_next;

    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        case (s_reg.st)
            ST_IDLE: begin
                if (start_i) begin
                    s_next.st = ST_ERASE;
                    // registered busy adds a cycle, so count stops one short
                    s_next.cnt = CNT_W'(ERASE_CYCLES_P - 2);
                end
            end
            ST_ERASE: begin
                // RL18: pending interrupt aborts
                if (abort_i) begin
                    s_next.st = ST_IDLE;
                    s_next.done = 1'b1;
                    s_next.fail = 1'b1;
                // RL10: full erase time
                end else if (s_reg.cnt == '0) begin
                    s_next.st = ST_IDLE;
                    s_next.done = 1'b1;
                    s_next.fail = 1'b0;
                end else begin
                    s_next.cnt = s_reg.cnt - CNT_W'(1);
                end
            end
            default: s_next.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_reg <= '{st: ST_IDLE, cnt: '0, done: 1'b0, fail: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign busy_o = (s_reg.st == ST_ERASE);
    assign done_o = s_reg.done;
    assign fail_o = s_reg.fail;
endmodule
`default_nettype wire

/* hw/flash_boot_protect_sector_erase.sv */
// sector erase sequencer with boot-loader region guard
// Summary of operation
// RL1: refuse user-mode erase or program aimed inside the enabled boot region.
// RL2: boot region exists only when the option enable bit is 0.
// RL3: tool program mode may still erase and program the boot region; here tool mode only gets program writes, erase is refused.
// RL4: option bits 2..0 size the region starting at 100H.
// RL5: option bits 7..5 pick the post power-on reset vector.
// RL6: vector field and size field decode independently; the code also gates the vector with enable bit 3 and bit 4.
// RL7: sector erase only in user program mode, never in tool modes.
// RL8: memory is 512 sectors of 128 bytes each.
// RL9: software erases a sector before writing bytes into it.
// RL10: erase runs 10 ms after the start bit is set.
// RL11: software enables only the interrupts allowed to abort an erase.
// RL12: erase triggers accepted only while key A5 is present.
// RL13: software loads sector address before the trigger.
// RL14: control write A1 selects sector erase and starts it.
// RL15: control bit 3 shows erase status, 1 means failed.
// RL16: software issues two no-ops after the trigger.
// RL17: user mode enabled only while the key register holds A5.
// RL18: enabled pending interrupt aborts the erase, status reads fail.
// RL19: low sector address bits 6..0 are ignored.
// RL20: busy held internally; status changes only when operation ends.
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module flash_boot_protect_sector_erase
    import flash_seq_pkg::*;
#(
    parameter int ERASE_CYCLES_P = ERASE_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic tool_mode_i,
    input wire logic emulator_tool_mode_i,
    input wire logic irq_pending_i,
    input wire logic [7:0] option_byte_i,
    output logic [7:0] rdata_o,
    output logic erase_req_o,
    output logic [15:0] erase_base_o,
    output logic pm_write_grant_o,
    output logic [15:0] reset_vector_o,
    output logic busy_o
);
    import flash_seq_pkg::*;

    typedef struct packed {
        logic tool_m;
        logic tool_s;
        logic emu_m;
        logic emu_s;
        logic irq_m;
        logic irq_s;
        logic [7:0] opt_m;
        logic [7:0] opt_s;
    } sync_s;

    typedef struct packed {
        logic [7:0] key;
        logic [3:0] mode;
        logic status;
        logic [7:0] sec_high;
        logic sec_low7;
        logic [7:0] option;
        logic opt_loaded;
        logic [1:0] opt_wait;
        logic [15:0] pm_addr;
        logic pm_refused;
        logic pm_grant;
        erase_cmd_s cmd;
        logic [7:0] rdata;
        logic [15:0] vector;
        logic busy;
    } core_s;

    sync_s y_reg, y_next;
    core_s s_reg, s_next;
    reg_req_s req;
    logic region_en;
    logic [15:0] region_last;
    logic [15:0] vector;
    logic t_busy;
    logic t_done;
    logic t_fail;
    logic user_mode;
    logic in_region;

    function automatic logic hits_region(input logic [15:0] a, input logic en,
                                         input logic [15:0] last);
        hits_region = en && (a >= REGION_BASE) && (a <= last);
    endfunction

    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    region_decode u_decode (
        .option_i(s_reg.option),
        .region_en_o(region_en),
        .region_last_o(region_last),
        .vector_o(vector)
    );

    erase_timer #(
        .ERASE_CYCLES_P(ERASE_CYCLES_P)
    ) u_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(s_next.cmd.req),
        .abort_i(y_reg.irq_s),
        .busy_o(t_busy),
        .done_o(t_done),
        .fail_o(t_fail)
    );

    // pin inputs pass two flops before use
    always_comb begin
        y_next = y_reg;
        y_next.tool_m = tool_mode_i;
        y_next.tool_s = y_reg.tool_m;
        y_next.emu_m = emulator_tool_mode_i;
        y_next.emu_s = y_reg.emu_m;
        y_next.irq_m = irq_pending_i;
        y_next.irq_s = y_reg.irq_m;
        y_next.opt_m = option_byte_i;
        y_next.opt_s = y_reg.opt_m;
    end

    always_comb begin
        s_next = s_reg;
        s_next.cmd.req = 1'b0;
        s_next.rdata = 8'h00;
        // RL17: key gate for user mode
        user_mode = (s_reg.key == KEY_VALUE) && !y_reg.tool_s && !y_reg.emu_s;
        in_region = hits_region(s_reg.pm_addr, region_en, region_last);
        // option byte captured once after reset release, vector follows
        if (!s_reg.opt_loaded) begin
            if (s_reg.opt_wait == OPT_SETTLE) begin
                s_next.option = y_reg.opt_s;
                s_next.opt_loaded = 1'b1;
            end else begin
                s_next.opt_wait = s_reg.opt_wait + 2'h1;
            end
        end
        s_next.vector = vector;
        // RL20: status only on completion
        if (t_done) begin
            // RL15 RL18: fail flag from abort
            s_next.status = t_fail;
        end
        s_next.busy = t_busy || s_next.cmd.req;
        if (req.wr) begin
            if (req.addr == OFS_FLASH_CONTROL) begin
                s_next.mode = req.wdata[7:4];
                // RL7 RL12 RL14: erase start only in user mode with key
                if (req.wdata[CTRL_START_BIT] && req.wdata[7:4] == MODE_SECTOR_ERASE
                    && user_mode && !s_reg.busy) begin
                    // RL1 RL2: guard boot region in user mode
                    if (!hits_region({s_reg.sec_high, s_reg.sec_low7, 7'h00},
                                     region_en, region_last)) begin
                        s_next.cmd.req = 1'b1;
                        // RL8 RL19: 128-byte sector base
                        s_next.cmd.base = {s_reg.sec_high, s_reg.sec_low7, 7'h00};
                        s_next.busy = 1'b1;
                    end else begin
                        s_next.status = 1'b1;
                    end
                end
            end else if (req.addr == OFS_PROGRAM_ENABLE_KEY) begin
                s_next.key = req.wdata;
            end else if (req.addr == OFS_SECTOR_ADDR_HIGH) begin
                s_next.sec_high = req.wdata;
            end else if (req.addr == OFS_SECTOR_ADDR_LOW) begin
                // RL19: low bits 6..0 dropped
                s_next.sec_low7 = req.wdata[7];
            end else if (req.addr == OFS_PM_WRITE_HIGH) begin
                s_next.pm_addr[15:8] = req.wdata;
            end else if (req.addr == OFS_PM_WRITE_LOW) begin
                s_next.pm_addr[7:0] = req.wdata;
                s_next.pm_grant = 1'b0;
                s_next.pm_refused = 1'b0;
                // RL3: tool mode bypasses the guard
                if (y_reg.tool_s) begin
                    s_next.pm_grant = 1'b1;
                end else if (user_mode && s_reg.mode == MODE_BYTE_PROGRAM) begin
                    // RL1: user program write into region refused
                    if (hits_region({s_reg.pm_addr[15:8], req.wdata}, region_en,
                                    region_last)) begin
                        s_next.pm_refused = 1'b1;
                    end else begin
                        s_next.pm_grant = 1'b1;
                    end
                end else begin
                    s_next.pm_refused = 1'b1;
                end
            end
        end
        if (req.rd) begin
            if (req.addr == OFS_FLASH_CONTROL) begin
                s_next.rdata = {s_reg.mode, s_reg.status, 3'b000};
            end else if (req.addr == OFS_PROGRAM_ENABLE_KEY) begin
                s_next.rdata = s_reg.key;
            end else if (req.addr == OFS_SECTOR_ADDR_HIGH) begin
                s_next.rdata = s_reg.sec_high;
            end else if (req.addr == OFS_SECTOR_ADDR_LOW) begin
                s_next.rdata = {s_reg.sec_low7, 7'h00};
            end else if (req.addr == OFS_OPTION_BYTE) begin
                s_next.rdata = s_reg.option;
            end else if (req.addr == OFS_PM_WRITE_HIGH) begin
                s_next.rdata = s_reg.pm_addr[15:8];
            end else if (req.addr == OFS_PM_WRITE_LOW) begin
                s_next.rdata = s_reg.pm_addr[7:0];
            end else if (req.addr == OFS_PM_STATUS) begin
                s_next.rdata = {5'h00, in_region, s_reg.pm_refused, s_reg.pm_grant};
            end else if (req.addr == OFS_RESET_VECTOR_HIGH) begin
                s_next.rdata = s_reg.vector[15:8];
            end else if (req.addr == OFS_RESET_VECTOR_LOW) begin
                s_next.rdata = s_reg.vector[7:0];
            end else begin
                s_next.rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            y_reg <= '0;
            s_reg <= '0;
            s_reg.key <= KEY_RESET;
            s_reg.option <= OPTION_RESET;
            s_reg.vector <= VECTOR_DEFAULT;
        end else begin
            y_reg <= y_next;
            s_reg <= s_next;
        end
    end

    assign rdata_o = s_reg.rdata;
    assign erase_req_o = s_reg.cmd.req;
    assign erase_base_o = s_reg.cmd.base;
    assign pm_write_grant_o = s_reg.pm_grant;
    assign reset_vector_o = s_reg.vector;
    assign busy_o = s_reg.busy;
endmodule
`default_nettype wire

/* hw/flash_seq_pkg.sv */
// shared constants and carrier types for the flash sector-erase sequencer
package flash_seq_pkg;
    // register offsets on the plain register port
    localparam logic [3:0] OFS_FLASH_CONTROL = 4'h0;
    localparam logic [3:0] OFS_PROGRAM_ENABLE_KEY = 4'h1;
    localparam logic [3:0] OFS_SECTOR_ADDR_HIGH = 4'h2;
    localparam logic [3:0] OFS_SECTOR_ADDR_LOW = 4'h3;
    localparam logic [3:0] OFS_OPTION_BYTE = 4'h4;
    localparam logic [3:0] OFS_PM_WRITE_HIGH = 4'h5;
    localparam logic [3:0] OFS_PM_WRITE_LOW = 4'h6;
    localparam logic [3:0] OFS_PM_STATUS = 4'h7;
    localparam logic [3:0] OFS_RESET_VECTOR_HIGH = 4'h8;
    localparam logic [3:0] OFS_RESET_VECTOR_LOW = 4'h9;
    // key and command values
    localparam logic [7:0] KEY_VALUE = 8'hA5;
    localparam logic [7:0] KEY_RESET = 8'h00;
    localparam logic [3:0] MODE_SECTOR_ERASE = 4'hA;
    localparam logic [3:0] MODE_BYTE_PROGRAM = 4'h5;
    // field positions
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_STATUS_BIT = 3;
    localparam int OPT_SIZE_OFF_BIT = 2;
    localparam int OPT_VEC_OFF_BIT = 7;
    localparam int OPT_SEL_BIT = 4;
    localparam int OPT_ENABLE_BIT = 3;
    localparam logic [7:0] OPTION_RESET = 8'hFF;
    localparam logic [15:0] REGION_BASE = 16'h0100;
    localparam logic [15:0] VECTOR_DEFAULT = 16'h0100;
    // timing
    localparam int CLK_HZ = 40_000_000;
    localparam int ERASE_TIME_MS = 10;
    localparam int ERASE_CYCLES = CLK_HZ / 1000 * ERASE_TIME_MS;
    localparam int CNT_W = 19;
    // option pin settles through the two sync flops first
    localparam logic [1:0] OPT_SETTLE = 2'h2;

    typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_DONE} erase_state_e;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

    typedef struct packed {
        logic req;
        logic [15:0] base;
    } erase_cmd_s;
endpackage

/* hw/region_decode.sv */
// option byte decode into protected region end and reset vector
`timescale 1ns/1ps
`default_nettype none
module region_decode
    import flash_seq_pkg::*;
(
    input wire logic [7:0] option_i,
    output logic region_en_o,
    output logic [15:0] region_last_o,
    output logic [15:0] vector_o
);
    function automatic logic [15:0] span_last(input logic [1:0] code);
        case (code)
            2'd0: span_last = 16'h01FF;
            2'd1: span_last = 16'h02FF;
            2'd2: span_last = 16'h04FF;
            default: span_last = 16'h08FF;
        endcase
    endfunction

    always_comb begin
        // RL2 RL4: enable low, size from bits 2..0
        region_en_o = ~option_i[OPT_ENABLE_BIT] & ~option_i[OPT_SIZE_OFF_BIT];
        region_last_o = span_last(option_i[1:0]);
        vector_o = VECTOR_DEFAULT;
        // RL5 RL6: vector from bits 7..5, gated by bits 4 and 3
        if (~option_i[OPT_ENABLE_BIT] & ~option_i[OPT_SEL_BIT] & ~option_i[OPT_VEC_OFF_BIT]) begin
            vector_o = span_last(option_i[6:5]) + 16'h0001;
        end
    end
endmodule
`default_nettype wire
